// [core/noload_pkg.sv]
// Constants, types and helpers shared by the no-load detector files.
// Assumes a single 20 MHz clock and 28-bit signed DSP power samples.
//
// Behaviour
// - Fundamental no load when both fundamental power magnitudes are within thresholds.
// - In fundamental no load, fundamental energy and pulses of that phase stop.
// - Fundamental comparison reuses the shared active and reactive threshold registers.
// - Negative active or reactive thresholds disable fundamental no-load detection.
// - Status bit 1 sets when any phase changes fundamental no-load state.
// - Phase register bits 5..3 show fundamental state C,B,A, updated with flag.
// - Mask bit 1 set routes the fundamental flag onto the low interrupt line.
// - Writing status bit 1 as one clears it and releases the line.
// - Apparent no load when apparent power magnitude is within its threshold.
// - In apparent no load, apparent energy and pulses of that phase stop.
// - A negative apparent threshold disables apparent no-load detection.
// - Apparent threshold is signed 24 bits, zero padded to 32, extended to 28.
// - Registers transfer as 32, 16 or 8 bit words; processing uses 28 bits.
// - Status bit 2 sets when any phase enters or exits apparent no load.
// - Phase register bits 8..6 show apparent state C,B,A, updated with flag.
// - Mask bit 2 set routes the apparent flag onto the low interrupt line.
// - Writing status bit 2 as one clears it and releases the line.
// - Active and reactive thresholds are signed 24-bit positive power levels.
// - Flags set regardless of mask; mask only gates the interrupt line.
// - Interrupt line is active low and stays low until enabled flags clear.
package noload_pkg;

  localparam int unsigned DSP_W = 28;
  localparam int unsigned THR_W = 24;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NPH = 3;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] ACTIVE_THR_OFS = 16'h0000;
  localparam logic [15:0] REACTIVE_THR_OFS = 16'h0004;
  localparam logic [15:0] APPARENT_THR_OFS = 16'h0008;
  localparam logic [15:0] SECOND_STATUS_OFS = 16'h000C;
  localparam logic [15:0] SECOND_MASK_OFS = 16'h0010;
  localparam logic [15:0] PHASE_NOLOAD_OFS = 16'h0014;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned FUND_FLAG_BIT = 1;
  localparam int unsigned APP_FLAG_BIT = 2;
  localparam int unsigned FUND_PH_LSB = 3;
  localparam int unsigned APP_PH_LSB = 6;
  localparam logic [23:0] THR_RESET = 24'h00_0000;
  localparam logic [1:0] FLAG_RESET = 2'h0;
  localparam logic [2:0] STATE_RESET = 3'h0;

  typedef enum logic [1:0] {
    SIZE_8 = 2'b00,
    SIZE_16 = 2'b01,
    SIZE_32 = 2'b10
  } xfer_size_e;

  // Magnitude of a 28-bit sample; -2^27 still fits unsigned
  function automatic logic [DSP_W-1:0] mag(input logic [DSP_W-1:0] v);
    mag = v[DSP_W-1] ? DSP_W'(~v + 28'h000_0001) : v;
  endfunction

  function automatic logic [DSP_W-1:0] sext_thr(input logic [THR_W-1:0] t);
    sext_thr = {{(DSP_W-THR_W){t[THR_W-1]}}, t};
  endfunction

  // Narrow serial words replace only the low bytes
  function automatic logic [THR_W-1:0] merge_thr(input logic [THR_W-1:0] old_v,
                                                 input logic [WORD_W-1:0] w,
                                                 input logic [1:0] size);
    logic [THR_W-1:0] r;
    r = old_v;
    if (size == SIZE_8) begin
      r[7:0] = w[7:0];
    end else if (size == SIZE_16) begin
      r[15:0] = w[15:0];
    end else begin
      r = w[THR_W-1:0];
    end
    merge_thr = r;
  endfunction

endpackage

// [core/noload_mag_cmp.sv]
// Magnitude-versus-threshold compare for one power quantity.
// Assumes a 28-bit signed sample and a 24-bit signed threshold.
`timescale 1ns/1ps
module noload_mag_cmp (
  // Sample and limit
  input wire logic [noload_pkg::DSP_W-1:0] power,
  input wire logic [noload_pkg::THR_W-1:0] thr,
  // Result
  output logic below
);
  import noload_pkg::*;

  logic [DSP_W-1:0] thr_ext;

  always_comb begin
    thr_ext = sext_thr(thr);
    // Negative limit switches the detector off
    below = !thr[THR_W-1] && (mag(power) <= thr_ext);
  end

endmodule

// [core/noload_energy_gate.sv]
// Gates one phase's power sample and pulse request while in no load.
// Assumes sample_valid marks new power data, one cycle wide.
`timescale 1ns/1ps
module noload_energy_gate (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic soft_rst,
  // Sample side
  input wire logic sample_valid,
  input wire logic noload,
  input wire logic [noload_pkg::DSP_W-1:0] power_in,
  input wire logic pulse_in,
  // Accumulator side
  output logic [noload_pkg::DSP_W-1:0] power_out,
  output logic pulse_out
);
  import noload_pkg::*;

  logic [DSP_W-1:0] power_reg;
  logic [DSP_W-1:0] power_next;

  always_comb begin
    power_next = power_reg;
    if (soft_rst) begin
      power_next = '0;
    end else if (sample_valid) begin
      // Zero power means nothing accumulates
      power_next = noload ? '0 : power_in;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      power_reg <= '0;
    end else begin
      power_reg <= power_next;
    end
  end

  assign power_out = power_reg;
  assign pulse_out = pulse_in && !noload;

endmodule

// [core/noload_detector.sv]
// Per-phase fundamental and apparent no-load detector with its registers.
// Assumes register strobes from the serial port front end, one cycle each.
`timescale 1ns/1ps
module noload_detector (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic soft_rst,
  // Power samples, phase A in index 0
  input wire logic sample_valid,
  input wire logic [noload_pkg::NPH-1:0][noload_pkg::DSP_W-1:0] fund_active_pwr,
  input wire logic [noload_pkg::NPH-1:0][noload_pkg::DSP_W-1:0] fund_reactive_pwr,
  input wire logic [noload_pkg::NPH-1:0][noload_pkg::DSP_W-1:0] apparent_pwr,
  // Pulse requests from energy-to-frequency stages
  input wire logic [noload_pkg::NPH-1:0] fund_active_pulse_req,
  input wire logic [noload_pkg::NPH-1:0] fund_reactive_pulse_req,
  input wire logic [noload_pkg::NPH-1:0] apparent_pulse_req,
  // Gated powers to the energy accumulators
  output logic [noload_pkg::NPH-1:0][noload_pkg::DSP_W-1:0] fund_active_acc,
  output logic [noload_pkg::NPH-1:0][noload_pkg::DSP_W-1:0] fund_reactive_acc,
  output logic [noload_pkg::NPH-1:0][noload_pkg::DSP_W-1:0] apparent_acc,
  output logic [noload_pkg::NPH-1:0] fund_accum_en,
  output logic [noload_pkg::NPH-1:0] apparent_accum_en,
  // Gated pulse requests to the calibration outputs
  output logic [noload_pkg::NPH-1:0] fund_active_pulse,
  output logic [noload_pkg::NPH-1:0] fund_reactive_pulse,
  output logic [noload_pkg::NPH-1:0] apparent_pulse,
  // Register port from the serial interface
  input wire logic [noload_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_size,
  input wire logic [noload_pkg::WORD_W-1:0] reg_wdata,
  output logic [noload_pkg::WORD_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Interrupt
  output logic second_irq_line_n
);
  import noload_pkg::*;

  // ---------------------------------------------------------------
  // Threshold registers
  // ---------------------------------------------------------------
  logic [THR_W-1:0] active_noload_threshold_reg;
  logic [THR_W-1:0] active_noload_threshold_next;

  logic [THR_W-1:0] reactive_noload_threshold_reg;
  logic [THR_W-1:0] reactive_noload_threshold_next;

  logic [THR_W-1:0] apparent_noload_threshold_reg;
  logic [THR_W-1:0] apparent_noload_threshold_next;

  logic wr_active;
  logic wr_reactive;
  logic wr_apparent;
  logic wr_status;
  logic wr_mask;

  always_comb begin
    wr_active = reg_wr && (reg_addr == ACTIVE_THR_OFS);
    wr_reactive = reg_wr && (reg_addr == REACTIVE_THR_OFS);
    wr_apparent = reg_wr && (reg_addr == APPARENT_THR_OFS);
    wr_status = reg_wr && (reg_addr == SECOND_STATUS_OFS);
    wr_mask = reg_wr && (reg_addr == SECOND_MASK_OFS);
  end

  always_comb begin
    active_noload_threshold_next = active_noload_threshold_reg;
    reactive_noload_threshold_next = reactive_noload_threshold_reg;
    apparent_noload_threshold_next = apparent_noload_threshold_reg;
    if (soft_rst) begin
      active_noload_threshold_next = THR_RESET;
      reactive_noload_threshold_next = THR_RESET;
      apparent_noload_threshold_next = THR_RESET;
    end else begin
      // Upper byte of a 32-bit write is padding and is dropped
      if (wr_active) begin
        active_noload_threshold_next = merge_thr(active_noload_threshold_reg, reg_wdata, reg_size);
      end
      if (wr_reactive) begin
        reactive_noload_threshold_next = merge_thr(reactive_noload_threshold_reg, reg_wdata, reg_size);
      end
      if (wr_apparent) begin
        apparent_noload_threshold_next = merge_thr(apparent_noload_threshold_reg, reg_wdata, reg_size);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      active_noload_threshold_reg <= THR_RESET;
      reactive_noload_threshold_reg <= THR_RESET;
      apparent_noload_threshold_reg <= THR_RESET;
    end else begin
      active_noload_threshold_reg <= active_noload_threshold_next;
      reactive_noload_threshold_reg <= reactive_noload_threshold_next;
      apparent_noload_threshold_reg <= apparent_noload_threshold_next;
    end
  end

  // ---------------------------------------------------------------
  // Per-phase comparisons
  // ---------------------------------------------------------------
  logic [NPH-1:0] act_below;
  logic [NPH-1:0] react_below;
  logic [NPH-1:0] app_below;

  logic [NPH-1:0] fund_cond;

  for (genvar p = 0; p < NPH; p++) begin : g_cmp
    // Same limits as the total-power detector; no separate set
    noload_mag_cmp u_act_cmp (
      .power(fund_active_pwr[p]),
      .thr(active_noload_threshold_reg),
      .below(act_below[p])
    );
    noload_mag_cmp u_react_cmp (
      .power(fund_reactive_pwr[p]),
      .thr(reactive_noload_threshold_reg),
      .below(react_below[p])
    );
    noload_mag_cmp u_app_cmp (
      .power(apparent_pwr[p]),
      .thr(apparent_noload_threshold_reg),
      .below(app_below[p])
    );
  end

  // Either negative limit switches fundamental detection off
  assign fund_cond = act_below & react_below;

  // ---------------------------------------------------------------
  // Phase state, flags and mask
  // ---------------------------------------------------------------
  logic [NPH-1:0] fund_noload_phase_state_reg;
  logic [NPH-1:0] fund_noload_phase_state_next;
  logic [NPH-1:0] apparent_noload_phase_state_reg;
  logic [NPH-1:0] apparent_noload_phase_state_next;

  logic fund_noload_flag_reg;
  logic fund_noload_flag_next;
  logic apparent_noload_flag_reg;
  logic apparent_noload_flag_next;

  logic fund_mask_reg;
  logic fund_mask_next;
  logic apparent_mask_reg;
  logic apparent_mask_next;

  logic fund_change;
  logic app_change;

  always_comb begin
    fund_noload_phase_state_next = fund_noload_phase_state_reg;
    apparent_noload_phase_state_next = apparent_noload_phase_state_reg;
    if (sample_valid) begin
      fund_noload_phase_state_next = fund_cond;
      apparent_noload_phase_state_next = app_below;
    end
    if (soft_rst) begin
      fund_noload_phase_state_next = STATE_RESET;
      apparent_noload_phase_state_next = STATE_RESET;
    end
    fund_change = sample_valid && (fund_cond != fund_noload_phase_state_reg);
    app_change = sample_valid && (app_below != apparent_noload_phase_state_reg);
  end

  always_comb begin
    fund_noload_flag_next = fund_noload_flag_reg;
    apparent_noload_flag_next = apparent_noload_flag_reg;
    fund_mask_next = fund_mask_reg;
    apparent_mask_next = apparent_mask_reg;
    // Write-one-to-clear; a change in the same cycle wins
    if (wr_status && reg_wdata[FUND_FLAG_BIT]) begin
      fund_noload_flag_next = 1'b0;
    end
    if (wr_status && reg_wdata[APP_FLAG_BIT]) begin
      apparent_noload_flag_next = 1'b0;
    end
    // Flags set whatever the mask says
    if (fund_change) begin
      fund_noload_flag_next = 1'b1;
    end
    if (app_change) begin
      apparent_noload_flag_next = 1'b1;
    end
    // Mask bits other than 1 and 2 are not kept
    if (wr_mask) begin
      fund_mask_next = reg_wdata[FUND_FLAG_BIT];
      apparent_mask_next = reg_wdata[APP_FLAG_BIT];
    end
    if (soft_rst) begin
      fund_noload_flag_next = 1'b0;
      apparent_noload_flag_next = 1'b0;
      fund_mask_next = 1'b0;
      apparent_mask_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fund_noload_phase_state_reg <= STATE_RESET;
      apparent_noload_phase_state_reg <= STATE_RESET;
      fund_noload_flag_reg <= FLAG_RESET[0];
      apparent_noload_flag_reg <= FLAG_RESET[0];
      fund_mask_reg <= FLAG_RESET[0];
      apparent_mask_reg <= FLAG_RESET[0];
    end else begin
      // State bits and flag move on the same edge
      fund_noload_phase_state_reg <= fund_noload_phase_state_next;
      apparent_noload_phase_state_reg <= apparent_noload_phase_state_next;
      fund_noload_flag_reg <= fund_noload_flag_next;
      apparent_noload_flag_reg <= apparent_noload_flag_next;
      fund_mask_reg <= fund_mask_next;
      apparent_mask_reg <= apparent_mask_next;
    end
  end

  logic fund_irq;
  logic app_irq;

  assign fund_irq = fund_noload_flag_reg && fund_mask_reg;
  assign app_irq = apparent_noload_flag_reg && apparent_mask_reg;
  // Low while any enabled flag stands
  assign second_irq_line_n = !(fund_irq || app_irq);

  // ---------------------------------------------------------------
  // Energy and pulse gating
  // ---------------------------------------------------------------
  // Gating uses the fresh comparison so the very sample that enters
  // no load is already withheld from the accumulators.
  logic [NPH-1:0] fund_gate;
  logic [NPH-1:0] app_gate;

  always_comb begin
    fund_gate = sample_valid ? fund_cond : fund_noload_phase_state_reg;
    app_gate = sample_valid ? app_below : apparent_noload_phase_state_reg;
  end

  for (genvar p = 0; p < NPH; p++) begin : g_gate
    noload_energy_gate u_fund_act_gate (
      .clock(clock),
      .nrst(nrst),
      .soft_rst(soft_rst),
      .sample_valid(sample_valid),
      .noload(fund_gate[p]),
      .power_in(fund_active_pwr[p]),
      .pulse_in(fund_active_pulse_req[p]),
      .power_out(fund_active_acc[p]),
      .pulse_out(fund_active_pulse[p])
    );
    noload_energy_gate u_fund_react_gate (
      .clock(clock),
      .nrst(nrst),
      .soft_rst(soft_rst),
      .sample_valid(sample_valid),
      .noload(fund_gate[p]),
      .power_in(fund_reactive_pwr[p]),
      .pulse_in(fund_reactive_pulse_req[p]),
      .power_out(fund_reactive_acc[p]),
      .pulse_out(fund_reactive_pulse[p])
    );
    noload_energy_gate u_app_gate (
      .clock(clock),
      .nrst(nrst),
      .soft_rst(soft_rst),
      .sample_valid(sample_valid),
      .noload(app_gate[p]),
      .power_in(apparent_pwr[p]),
      .pulse_in(apparent_pulse_req[p]),
      .power_out(apparent_acc[p]),
      .pulse_out(apparent_pulse[p])
    );
  end

  assign fund_accum_en = ~fund_noload_phase_state_reg;
  assign apparent_accum_en = ~apparent_noload_phase_state_reg;

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] rdata_reg;
  logic [WORD_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  logic [WORD_W-1:0] rd_word;

  logic [WORD_W-1:0] status_word;
  logic [WORD_W-1:0] mask_word;
  logic [WORD_W-1:0] phase_word;

  always_comb begin
    status_word = '0;
    status_word[FUND_FLAG_BIT] = fund_noload_flag_reg;
    status_word[APP_FLAG_BIT] = apparent_noload_flag_reg;
    mask_word = '0;
    mask_word[FUND_FLAG_BIT] = fund_mask_reg;
    mask_word[APP_FLAG_BIT] = apparent_mask_reg;
    phase_word = '0;
    phase_word[FUND_PH_LSB +: NPH] = fund_noload_phase_state_reg;
    phase_word[APP_PH_LSB +: NPH] = apparent_noload_phase_state_reg;
  end

  always_comb begin
    unique case (reg_addr)
      // Thresholds read back with the top byte as zero
      ACTIVE_THR_OFS: rd_word = {8'h00, active_noload_threshold_reg};
      REACTIVE_THR_OFS: rd_word = {8'h00, reactive_noload_threshold_reg};
      APPARENT_THR_OFS: rd_word = {8'h00, apparent_noload_threshold_reg};
      SECOND_STATUS_OFS: rd_word = status_word;
      SECOND_MASK_OFS: rd_word = mask_word;
      PHASE_NOLOAD_OFS: rd_word = phase_word;
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_rd) begin
      rvalid_next = 1'b1;
      // Narrow reads return the low bytes, zero extended
      unique case (reg_size)
        SIZE_8: rdata_next = {24'h00_0000, rd_word[7:0]};
        SIZE_16: rdata_next = {16'h0000, rd_word[15:0]};
        default: rdata_next = rd_word;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

endmodule

// [tb/noload_detector_assertions.sv]
// Port checker for the no-load detector.
// Assumes one clock domain with an async low reset.
`timescale 1ns/1ps
module noload_detector_assertions
  import noload_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic soft_rst,
  input wire logic sample_valid,
  input wire logic [NPH-1:0][DSP_W-1:0] apparent_pwr,
  input wire logic [NPH-1:0][DSP_W-1:0] fund_active_acc,
  input wire logic [NPH-1:0][DSP_W-1:0] apparent_acc,
  input wire logic [NPH-1:0] fund_accum_en,
  input wire logic [NPH-1:0] apparent_accum_en,
  input wire logic [NPH-1:0] fund_active_pulse_req,
  input wire logic [NPH-1:0] apparent_pulse_req,
  input wire logic [NPH-1:0] fund_active_pulse,
  input wire logic [NPH-1:0] apparent_pulse,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [WORD_W-1:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic second_irq_line_n
);
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_rd_answer;
    reg_rd && !soft_rst |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rvalid_cause;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read answer");
  property p_fund_pulse;
    !sample_valid |-> fund_active_pulse == (fund_active_pulse_req & fund_accum_en);
  endproperty
  a_fund_pulse: assert property (p_fund_pulse) else $error("fund pulse gating");
  property p_app_pulse;
    !sample_valid |-> apparent_pulse == (apparent_pulse_req & apparent_accum_en);
  endproperty
  a_app_pulse: assert property (p_app_pulse) else $error("apparent pulse gating");
  property p_fund_acc_zero;
    $past(sample_valid) && !fund_accum_en[0] |-> fund_active_acc[0] == '0;
  endproperty
  a_fund_acc_zero: assert property (p_fund_acc_zero) else $error("fund energy not held");
  property p_app_acc_pass;
    $past(sample_valid) && !$past(soft_rst) && apparent_accum_en[1] |-> apparent_acc[1] == $past(apparent_pwr[1]);
  endproperty
  a_app_acc_pass: assert property (p_app_acc_pass) else $error("apparent sample lost");
  property p_state_hold;
    !sample_valid && !soft_rst |=> $stable(fund_accum_en) && $stable(apparent_accum_en);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved without sample");
  property p_irq_clear;
    reg_wr && reg_addr == SECOND_STATUS_OFS && reg_wdata[2:1] == 2'b11 && !sample_valid |=> second_irq_line_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not released");
  property p_irq_fall;
    $fell(second_irq_line_n) |-> $past(sample_valid) || $past(reg_wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
  c_irq: cover property (sample_valid ##1 !second_irq_line_n);
  c_release: cover property ($rose(second_irq_line_n));
  c_read: cover property (reg_rvalid);
endmodule

bind noload_detector noload_detector_assertions i_chk (.clock, .nrst, .soft_rst, .sample_valid,
  .apparent_pwr, .fund_active_acc, .apparent_acc, .fund_accum_en, .apparent_accum_en,
  .fund_active_pulse_req, .apparent_pulse_req, .fund_active_pulse, .apparent_pulse,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid, .second_irq_line_n);

// [tb/noload_host_model.sv]
// Host controller model on the register port.
// Assumes read data arrives one cycle after the request.
`timescale 1ns/1ps
module noload_host_model
  import noload_pkg::*;
(
  input wire logic clock,
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [1:0] reg_size,
  output logic [WORD_W-1:0] reg_wdata,
  input wire logic [WORD_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ---------------------------------------------
  // Bus tasks
  // ---------------------------------------------
  localparam int FULL_SCALE_POWER = 33516139;
  initial begin
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_size = SIZE_32;
    reg_wdata = '0;
  end
  // Ratios in per mille of full scale
  function automatic logic [WORD_W-1:0] noload_thr(input int v_pm, input int i_pm);
    noload_thr = WORD_W'(longint'(FULL_SCALE_POWER) * v_pm * i_pm / 1000000);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_size <= s;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // Stale data must not look valid
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [1:0] s, output logic [31:0] d, output logic ok);
    @(posedge clock);
    reg_addr <= a;
    reg_size <= s;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
    ok = reg_rvalid;
  endtask
  // Phase register is read before the flags are written back
  task automatic service(output logic [31:0] st, output logic [31:0] ph);
    logic ok;
    rd(SECOND_STATUS_OFS, SIZE_32, st, ok);
    rd(PHASE_NOLOAD_OFS, SIZE_32, ph, ok);
    wr(SECOND_STATUS_OFS, st, SIZE_32);
  endtask
endmodule

// [tb/no_load_detector_test.sv]
// Directed bench for the no-load detector.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module no_load_detector_test
  import noload_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic soft_rst = 1'b0;
  logic sample_valid = 1'b0;
  logic [NPH-1:0][DSP_W-1:0] pa = '0, pq = '0, ps = '0, v_p, v_q, v_s, fa_acc, ap_acc, fq_acc;
  logic [NPH-1:0] req_f = 3'b111, req_q = 3'b101, req_a = 3'b011, en_f, en_a, pl_f, pl_q;
  logic [ADDR_W-1:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, irq_n;
  logic [1:0] reg_size;
  logic [WORD_W-1:0] reg_wdata, reg_rdata, st, ph;
  logic [15:0] ofs [4] = '{SECOND_STATUS_OFS, SECOND_MASK_OFS, PHASE_NOLOAD_OFS, APPARENT_THR_OFS};
  int fails = 0;
  int n_checks = 0;

  always #25 clock = ~clock;

  noload_detector i_dut (.clock(clock), .nrst(nrst), .soft_rst(soft_rst), .sample_valid(sample_valid),
    .fund_active_pwr(pa), .fund_reactive_pwr(pq), .apparent_pwr(ps), .fund_active_pulse_req(req_f),
    .fund_reactive_pulse_req(req_q), .apparent_pulse_req(req_a), .fund_active_acc(fa_acc),
    .fund_reactive_acc(fq_acc), .apparent_acc(ap_acc), .fund_accum_en(en_f), .apparent_accum_en(en_a),
    .fund_active_pulse(pl_f), .fund_reactive_pulse(pl_q), .apparent_pulse(), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_size(reg_size), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .second_irq_line_n(irq_n));

  noload_host_model i_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [1:0] s, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    i_host.rd(a, s, d, ok);
    chk("rvalid", 32'h0000_0001, {31'h0, ok});
    chk("rdata", exp, d);
  endtask
  task automatic samp();
    @(posedge clock);
    sample_valid <= 1'b1;
    pa <= v_p;
    pq <= v_q;
    ps <= v_s;
    @(posedge clock);
    sample_valid <= 1'b0;
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    conclude();
  end

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    foreach (ofs[i]) begin
      rchk(ofs[i], SIZE_32, 32'h0000_0000);
    end
    i_host.wr(ACTIVE_THR_OFS, 32'h0000_0064, SIZE_32);
    i_host.wr(REACTIVE_THR_OFS, 32'h0000_0064, SIZE_32);
    i_host.wr(APPARENT_THR_OFS, i_host.noload_thr(500, 2), SIZE_32);
    rchk(APPARENT_THR_OFS, SIZE_32, 32'h0000_82EC);
    i_host.wr(SECOND_MASK_OFS, 32'hFFFF_FFFF, SIZE_32);
    rchk(SECOND_MASK_OFS, SIZE_32, 32'h0000_0006);
    // Boundary magnitudes sit exactly on the limits or one count above them
    v_p = {28'h000_0000, 28'h000_0065, 28'hFFF_FF9C};
    v_q = {28'hFFF_FF9B, 28'h000_0000, 28'h000_0032};
    v_s = {28'hFFF_7D14, 28'h000_82ED, 28'h000_82EC};
    samp();
    chk("irq", 32'h0000_0000, {31'h0, irq_n});
    chk("fund_en", 32'h0000_0006, {29'h0, en_f});
    chk("app_en", 32'h0000_0002, {29'h0, en_a});
    chk("fund_pulse", 32'h0000_0006, {29'h0, pl_f});
    chk("fq_pulse", 32'h0000_0004, {29'h0, pl_q});
    chk("fq_acc", 32'h0FFF_FF9B, {4'h0, fq_acc[2]});
    chk("fa_acc", 32'h0000_0065, {4'h0, fa_acc[1]});
    chk("ap_acc", 32'h0000_0000, {4'h0, ap_acc[0]});
    i_host.service(st, ph);
    chk("status", 32'h0000_0006, st);
    chk("phase", 32'h0000_0148, ph);
    chk("irq", 32'h0000_0001, {31'h0, irq_n});
    samp();
    rchk(SECOND_STATUS_OFS, SIZE_32, 32'h0000_0000);
    i_host.wr(SECOND_MASK_OFS, 32'h0000_0000, SIZE_32);
    v_p[0] = 28'h000_01F4;
    samp();
    chk("irq", 32'h0000_0001, {31'h0, irq_n});
    rchk(PHASE_NOLOAD_OFS, SIZE_32, 32'h0000_0140);
    rchk(SECOND_STATUS_OFS, SIZE_32, 32'h0000_0002);
    i_host.wr(SECOND_STATUS_OFS, 32'h0000_0002, SIZE_32);
    rchk(SECOND_STATUS_OFS, SIZE_32, 32'h0000_0000);
    i_host.wr(ACTIVE_THR_OFS, 32'h0080_0000, SIZE_32);
    i_host.wr(REACTIVE_THR_OFS, 32'h0080_0000, SIZE_32);
    i_host.wr(APPARENT_THR_OFS, 32'hFFFF_FFFF, SIZE_32);
    i_host.wr(APPARENT_THR_OFS, 32'h0000_1234, SIZE_16);
    i_host.wr(APPARENT_THR_OFS, 32'h0000_7756, SIZE_8);
    rchk(APPARENT_THR_OFS, SIZE_32, 32'h00FF_1256);
    rchk(APPARENT_THR_OFS, SIZE_16, 32'h0000_1256);
    rchk(APPARENT_THR_OFS, SIZE_8, 32'h0000_0056);
    rchk(16'h0020, SIZE_32, 32'h0000_0000);
    v_p = '0;
    v_q = '0;
    v_s = '0;
    samp();
    rchk(SECOND_STATUS_OFS, SIZE_32, 32'h0000_0004);
    rchk(PHASE_NOLOAD_OFS, SIZE_32, 32'h0000_0000);
    @(posedge clock);
    soft_rst <= 1'b1;
    @(posedge clock);
    soft_rst <= 1'b0;
    rchk(ACTIVE_THR_OFS, SIZE_32, 32'h0000_0000);
    rchk(SECOND_STATUS_OFS, SIZE_32, 32'h0000_0000);
    samp();
    rchk(PHASE_NOLOAD_OFS, SIZE_32, 32'h0000_01F8);
    rchk(SECOND_STATUS_OFS, SIZE_32, 32'h0000_0006);
    chk("irq", 32'h0000_0001, {31'h0, irq_n});
    conclude();
  end
endmodule
